// [hw/usf_status.sv]
`timescale 1ns/10ps
`include "usf_map.svh"

module usf_status
  import usf_pkg::*;
#(
  parameter bit SECOND_INST = 1'b0
) (
  input  wire logic        i_clk,             // 100 MHz clock
  input  wire logic        i_rst_n,           // async reset, low
  input  wire logic        i_ce,              // clock enable
  input  wire logic [7:0]  i_avs_address,     // byte address
  input  wire logic        i_avs_read,        // read request
  input  wire logic        i_avs_write,       // write request
  input  wire logic [31:0] i_avs_writedata,   // write data
  input  wire logic [3:0]  i_avs_byteenable,  // byte lanes
  output logic      [31:0] o_avs_readdata,    // read data
  output logic             o_avs_waitrequest, // stall
  input  wire logic        i_rx_start,        // start bit seen
  input  wire logic        i_rx_char_valid,   // char received
  input  wire logic [7:0]  i_rx_char,         // received char
  input  wire logic        i_rx_busy,         // rx path working
  input  wire logic        i_idle_line,       // idle line seen
  input  wire logic        i_baud_tick,       // one per baud
  input  wire logic        i_break_stop,      // break stop bit
  input  wire logic        i_tbe_set,         // tx data moved
  input  wire logic        i_tbe_clr,         // tx data written
  input  wire logic        i_tc_set,          // frame sent
  input  wire logic        i_deep_sleep,      // cpu deep sleep
  input  wire logic        i_cts_n,           // nCTS pin
  output logic             o_tx_en,           // tx enable
  output logic             o_rx_en,           // rx enable
  output logic             o_rx_mute,         // receiver muted
  output logic             o_break_req,       // break pending
  output logic             o_wake_irq,        // wake request
  output logic             o_match_irq,       // match request
  output logic             o_block_end_irq,   // block end request
  output logic             o_timeout_irq,     // timeout request
  output logic             o_cts_irq          // cts change request
);

  ////////////////////////////////////////////////////////////////////
  usf_state_t  st_q;
  usf_state_t  st_d;
  logic        req;
  logic        wr;
  logic [31:0] wmask;
  logic        sel_ctl;
  logic        sel_rt;
  logic        sel_cmd;
  logic        sel_stat;
  logic        sel_intc;
  logic        brk_wr;
  logic        mute_wr;
  logic        wuc_wr;
  logic        amc_wr;
  logic        ebc_wr;
  logic        rtc_wr;
  logic        ctsc_wr;
  logic        tcc_wr;
  logic        match;
  logic        wake_ev;
  logic [8:0]  blk_lim;
  logic        blk_hit;
  logic        blk_rst;
  logic        to_hit;
  logic        cts_chg;
  logic [31:0] stat;
  usf_wsrc_t   wsrc;

  localparam logic [31:0] STAT_RST = `USF_STAT_RST;

  ////////////////////////////////////////////////////////////////////
  // bus decode: one wait cycle, access completes when ack is high
  assign req      = i_avs_read | i_avs_write;
  assign wr       = i_avs_write & st_q.ack;
  assign wmask    = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                     {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  assign sel_ctl  = (i_avs_address == `USF_CTL_OFS);
  assign sel_rt   = (i_avs_address == `USF_RT_OFS);
  assign sel_cmd  = (i_avs_address == `USF_CMD_OFS);
  assign sel_stat = (i_avs_address == `USF_STAT_OFS);
  assign sel_intc = (i_avs_address == `USF_INTC_OFS);

  assign brk_wr  = wr & sel_cmd & wmask[`USF_B_BRKREQ]
                   & i_avs_writedata[`USF_B_BRKREQ];
  assign mute_wr = wr & sel_cmd & wmask[`USF_B_MUTEREQ]
                   & i_avs_writedata[`USF_B_MUTEREQ];
  assign wuc_wr  = wr & sel_intc & wmask[`USF_B_WUC]
                   & i_avs_writedata[`USF_B_WUC];
  assign amc_wr  = wr & sel_intc & wmask[`USF_B_AMC]
                   & i_avs_writedata[`USF_B_AMC];
  assign ebc_wr  = wr & sel_intc & wmask[`USF_B_EBC]
                   & i_avs_writedata[`USF_B_EBC];
  assign rtc_wr  = wr & sel_intc & wmask[`USF_B_RTC]
                   & i_avs_writedata[`USF_B_RTC];
  assign ctsc_wr = wr & sel_intc & wmask[`USF_B_CTSC]
                   & i_avs_writedata[`USF_B_CTSC];
  assign tcc_wr  = wr & sel_intc & wmask[`USF_B_TCC]
                   & i_avs_writedata[`USF_B_TCC];

  ////////////////////////////////////////////////////////////////////
  // event detection
  assign wsrc    = usf_wsrc_t'(st_q.ctl[`USF_B_WSRC +: 2]);
  assign match   = i_rx_char_valid
                   & (i_rx_char == st_q.ctl[`USF_B_ADDR +: 8]);
  always_comb begin
    unique case (wsrc)
      USF_WS_MATCH: wake_ev = match;
      USF_WS_START: wake_ev = i_rx_start;
      USF_WS_CHAR:  wake_ev = i_rx_char_valid;
      default:      wake_ev = 1'b0;
    endcase
  end

  assign blk_lim = {1'b0, st_q.block_length_value} + `USF_BLK_EXTRA;
  assign blk_hit = (st_q.bcnt >= blk_lim);
  assign blk_rst = ~st_q.ctl[`USF_B_RXEN] | ebc_wr
                   | (st_q.ctl[`USF_B_SC] & ~st_q.tx_buffer_empty);
  assign to_hit  = st_q.tarm & (st_q.tcnt >= st_q.rto);
  assign cts_chg = st_q.cts_s ^ st_q.cts_p;

  ////////////////////////////////////////////////////////////////////
  // status word; writes to it are dropped by the decode below
  always_comb begin
    stat                = 32'h00000000;
    stat[`USF_B_REA]    = st_q.rx_enable_ack;
    stat[`USF_B_TEA]    = st_q.tx_enable_ack;
    stat[`USF_B_WUF]    = st_q.deep_sleep_wake_flag;
    stat[`USF_B_RWU]    = st_q.rx_mute_state;
    stat[`USF_B_SBF]    = st_q.break_pending_flag;
    stat[`USF_B_AMF]    = st_q.station_match_flag;
    stat[`USF_B_BSY]    = i_rx_busy;
    stat[`USF_B_EBF]    = st_q.ebf;
    stat[`USF_B_RTF]    = st_q.rx_timeout_flag;
    stat[`USF_B_CTS]    = ~st_q.cts_s;
    stat[`USF_B_CLEAR_TO_SEND_CHANGE_FLAG]   = st_q.clear_to_send_change_flag;
    stat[`USF_B_TBE]    = st_q.tx_buffer_empty;
    stat[`USF_B_TC]     = st_q.tc;
    if (SECOND_INST) begin
      stat = stat & ~`USF_STAT_RSV2;
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d     = st_q;
    st_d.ack = req & ~st_q.ack;
    if (req & ~st_q.ack) begin
      unique case (1'b1)
        sel_ctl:  st_d.rdata = st_q.ctl;
        sel_rt:   st_d.rdata = {st_q.block_length_value, st_q.rto};
        sel_stat: st_d.rdata = stat;
        default:  st_d.rdata = 32'h00000000;
      endcase
    end
    if (wr & sel_ctl) begin
      st_d.ctl = (st_q.ctl & ~wmask) | (i_avs_writedata & wmask);
    end
    if (wr & sel_rt) begin
      {st_d.block_length_value, st_d.rto} = ({st_q.block_length_value, st_q.rto} & ~wmask)
                              | (i_avs_writedata & wmask);
    end

    // enable acknowledges
    st_d.rx_enable_ack = st_q.ctl[`USF_B_RXEN];
    st_d.tx_enable_ack = st_q.ctl[`USF_B_TXEN];

    // wakeup: enable low forces clear, else set wins over clear
    if (!st_q.ctl[`USF_B_DSWE]) begin
      st_d.deep_sleep_wake_flag = 1'b0;
    end else begin
      st_d.deep_sleep_wake_flag = (st_q.deep_sleep_wake_flag & ~wuc_wr) | wake_ev;
    end

    // mute: address mode uses char match, idle mode only via request
    if (st_q.ctl[`USF_B_WM]) begin
      if (match) begin
        st_d.rx_mute_state = 1'b0;
      end else if (i_rx_char_valid & i_rx_char[7] & ~st_q.rx_mute_state) begin
        st_d.rx_mute_state = 1'b1;
      end
    end else if (i_idle_line) begin
      st_d.rx_mute_state = 1'b0;
    end
    if (mute_wr) begin
      st_d.rx_mute_state = 1'b1;
    end

    st_d.break_pending_flag  = (st_q.break_pending_flag & ~i_break_stop) | brk_wr;
    st_d.station_match_flag  = (st_q.station_match_flag & ~amc_wr) | match;
    st_d.ebf  = (st_q.ebf & ~ebc_wr) | blk_hit;
    st_d.rx_timeout_flag  = (st_q.rx_timeout_flag & ~rtc_wr) | to_hit;
    st_d.clear_to_send_change_flag = (st_q.clear_to_send_change_flag & ~ctsc_wr) | cts_chg;
    st_d.tx_buffer_empty  = (st_q.tx_buffer_empty & ~i_tbe_clr) | i_tbe_set;
    st_d.tc   = (st_q.tc & ~(tcc_wr | i_tbe_clr)) | (i_tc_set & st_q.tx_buffer_empty);

    // nCTS synchroniser and edge history
    st_d.cts_m = i_cts_n;
    st_d.cts_s = st_q.cts_m;
    st_d.cts_p = st_q.cts_s;

    // block byte counter, saturating
    if (blk_rst) begin
      st_d.bcnt = 9'h000;
    end else if (i_rx_char_valid && st_q.bcnt != 9'h1FF) begin
      st_d.bcnt = st_q.bcnt + 9'h001;
    end

    // receiver timeout counter in baud ticks
    if (to_hit) begin
      st_d.tarm = 1'b0;
    end
    if (st_q.ctl[`USF_B_SC]) begin
      if (i_rx_start) begin
        st_d.tarm = 1'b1;
        st_d.tcnt = 24'h000000;
      end
    end else if (i_rx_char_valid) begin
      st_d.tarm = 1'b1;
      st_d.tcnt = 24'h000000;
    end else if (i_rx_start) begin
      st_d.tarm = 1'b0;
      st_d.tcnt = 24'h000000;
    end
    if (st_q.tarm && !to_hit && i_baud_tick && st_q.tcnt != 24'hFFFFFF) begin
      st_d.tcnt = st_q.tcnt + 24'h000001;
    end

    if (SECOND_INST) begin
      st_d.rx_enable_ack  = 1'b0;
      st_d.deep_sleep_wake_flag  = 1'b0;
      st_d.ebf  = 1'b0;
      st_d.rx_timeout_flag  = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q       <= '0;
      st_q.ctl   <= `USF_CTL_RST;
      st_q.tx_buffer_empty   <= STAT_RST[`USF_B_TBE];
      st_q.tc    <= STAT_RST[`USF_B_TC];
      st_q.cts_m <= 1'b1;
      st_q.cts_s <= 1'b1;
      st_q.cts_p <= 1'b1;
    end else if (i_ce) begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  assign o_avs_readdata    = st_q.rdata;
  // stall while frozen so a completed write is never lost
  assign o_avs_waitrequest = req & ~(st_q.ack & i_ce);
  assign o_tx_en           = st_q.ctl[`USF_B_TXEN];
  assign o_rx_en           = st_q.ctl[`USF_B_RXEN];
  assign o_rx_mute         = st_q.rx_mute_state;
  assign o_break_req       = st_q.break_pending_flag;
  assign o_wake_irq        = st_q.deep_sleep_wake_flag & st_q.ctl[`USF_B_WUIE]
                             & i_deep_sleep;
  assign o_match_irq       = st_q.station_match_flag & st_q.ctl[`USF_B_MATCH_IRQ_ENABLE];
  assign o_block_end_irq   = st_q.ebf & st_q.ctl[`USF_B_BLOCK_END_IRQ_ENABLE];
  assign o_timeout_irq     = st_q.rx_timeout_flag & st_q.ctl[`USF_B_TIMEOUT_IRQ_ENABLE];
  assign o_cts_irq         = st_q.clear_to_send_change_flag & st_q.ctl[`USF_B_CTSIE];

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_brk_req;
    i_ce && brk_wr && !SECOND_INST;
  endsequence
  sequence s_cts_quiet;
    (i_ce && $stable(i_cts_n)) [*3];
  endsequence

  property p_rea;
    i_ce && !SECOND_INST |=> st_q.rx_enable_ack == $past(st_q.ctl[`USF_B_RXEN]);
  endproperty
  a_rea: assert property (p_rea) else $error("rx ack lags enable");

  property p_tea;
    i_ce |=> st_q.tx_enable_ack == $past(st_q.ctl[`USF_B_TXEN]);
  endproperty
  a_tea: assert property (p_tea) else $error("tx ack lags enable");

  property p_wuf_set;
    i_ce && !SECOND_INST && st_q.ctl[`USF_B_DSWE] && wake_ev |=> st_q.deep_sleep_wake_flag;
  endproperty
  a_wuf_set: assert property (p_wuf_set) else $error("wake lost");

  property p_wuf_clr;
    i_ce && !st_q.ctl[`USF_B_DSWE] |=> !st_q.deep_sleep_wake_flag;
  endproperty
  a_wuf_clr: assert property (p_wuf_clr) else $error("wake kept");

  property p_wake_irq;
    o_wake_irq |-> st_q.deep_sleep_wake_flag && i_deep_sleep;
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("bad wake irq");

  property p_idle_mute;
    i_ce && !st_q.ctl[`USF_B_WM] && !mute_wr && !st_q.rx_mute_state |=> !st_q.rx_mute_state;
  endproperty
  a_idle_mute: assert property (p_idle_mute) else $error("self mute");

  property p_brk;
    s_brk_req |=> st_q.break_pending_flag && o_break_req;
  endproperty
  a_brk: assert property (p_brk) else $error("break not pending");

  property p_match;
    i_ce && i_rx_char_valid && i_rx_char == st_q.ctl[`USF_B_ADDR +: 8]
      |=> st_q.station_match_flag;
  endproperty
  a_match: assert property (p_match) else $error("match lost");

  property p_blk;
    i_ce && !SECOND_INST && st_q.bcnt >= {1'b0, st_q.block_length_value} + `USF_BLK_EXTRA
      |=> st_q.ebf;
  endproperty
  a_blk: assert property (p_blk) else $error("block end lost");

  property p_cts;
    s_cts_quiet |-> stat[`USF_B_CTS] == !i_cts_n;
  endproperty
  a_cts: assert property (p_cts) else $error("cts level wrong");

  property p_clear_to_send_change_flag;
    i_ce && st_q.cts_s != st_q.cts_p |=> st_q.clear_to_send_change_flag;
  endproperty
  a_clear_to_send_change_flag: assert property (p_clear_to_send_change_flag) else $error("cts change lost");

  property p_match_clr;
    i_ce && amc_wr && !match |=> !st_q.station_match_flag;
  endproperty
  a_match_clr: assert property (p_match_clr) else $error("match kept");

  property p_blk_clr;
    i_ce && ebc_wr && !blk_hit |=> !st_q.ebf;
  endproperty
  a_blk_clr: assert property (p_blk_clr) else $error("block end kept");

  property p_to_clr;
    i_ce && rtc_wr && !to_hit |=> !st_q.rx_timeout_flag;
  endproperty
  a_to_clr: assert property (p_to_clr) else $error("timeout kept");

  property p_brk_clr;
    i_ce && i_break_stop && !brk_wr |=> !st_q.break_pending_flag && !o_break_req;
  endproperty
  a_brk_clr: assert property (p_brk_clr) else $error("break kept");

  property p_mute_req;
    i_ce && mute_wr |=> st_q.rx_mute_state && o_rx_mute;
  endproperty
  a_mute_req: assert property (p_mute_req) else $error("mute request lost");

endmodule : usf_status

// [hw/usf_map.svh]
`ifndef USF_MAP_SVH
`define USF_MAP_SVH
// register byte offsets
`define USF_CTL_OFS   8'h00
`define USF_RT_OFS    8'h14
`define USF_CMD_OFS   8'h18
`define USF_STAT_OFS  8'h1C
`define USF_INTC_OFS  8'h20
// reset values
`define USF_CTL_RST   32'h00000000
`define USF_RT_RST    32'h00000000
`define USF_STAT_RST  32'h000000C0
// bits reserved in the reduced instance
`define USF_STAT_RSV2 32'h00501800
// status bit positions
`define USF_B_REA     22
`define USF_B_TEA     21
`define USF_B_WUF     20
`define USF_B_RWU     19
`define USF_B_SBF     18
`define USF_B_AMF     17
`define USF_B_BSY     16
`define USF_B_EBF     12
`define USF_B_RTF     11
`define USF_B_CTS     10
`define USF_B_CLEAR_TO_SEND_CHANGE_FLAG    9
`define USF_B_TBE     7
`define USF_B_TC      6
// command bits
`define USF_B_BRKREQ  1
`define USF_B_MUTEREQ 2
// flag clear bits
`define USF_B_WUC     20
`define USF_B_AMC     17
`define USF_B_EBC     12
`define USF_B_RTC     11
`define USF_B_CTSC    9
`define USF_B_TCC     6
// control register fields
`define USF_B_TXEN    0
`define USF_B_RXEN    1
`define USF_B_WM      2
`define USF_B_DSWE    3
`define USF_B_WSRC    4
`define USF_B_SC      6
`define USF_B_MATCH_IRQ_ENABLE    7
`define USF_B_BLOCK_END_IRQ_ENABLE    8
`define USF_B_TIMEOUT_IRQ_ENABLE    9
`define USF_B_WUIE    10
`define USF_B_CTSIE   11
`define USF_B_ADDR    24
// block length field and prologue bytes
`define USF_B_BLOCK_LENGTH_VALUE    24
`define USF_BLK_EXTRA 9'h004
`endif

// [hw/usf_pkg.sv]
package usf_pkg;
  typedef enum logic [1:0] {
    USF_WS_MATCH = 2'b00,
    USF_WS_START = 2'b01,
    USF_WS_CHAR  = 2'b11,
    USF_WS_RSVD  = 2'b10
  } usf_wsrc_t;

  typedef struct packed {
    logic [31:0] ctl;
    logic [7:0]  block_length_value;
    logic [23:0] rto;
    logic        rx_enable_ack;
    logic        tx_enable_ack;
    logic        deep_sleep_wake_flag;
    logic        rx_mute_state;
    logic        break_pending_flag;
    logic        station_match_flag;
    logic        ebf;
    logic        rx_timeout_flag;
    logic        clear_to_send_change_flag;
    logic        tx_buffer_empty;
    logic        tc;
    logic        cts_m;
    logic        cts_s;
    logic        cts_p;
    logic [8:0]  bcnt;
    logic [23:0] tcnt;
    logic        tarm;
    logic        ack;
    logic [31:0] rdata;
  } usf_state_t;
endpackage : usf_pkg

// [dv/usf_far_model.sv]
`timescale 1ns/10ps

module usf_far_model (
  input  wire logic       i_clk,           // clock
  output logic            o_rx_start,      // start bit seen
  output logic            o_rx_char_valid, // char received
  output logic [7:0]      o_rx_char,       // received char
  output logic            o_rx_busy,       // rx path working
  output logic            o_idle_line,     // idle line seen
  output logic            o_baud_tick,     // baud pulse
  output logic            o_break_stop,    // break stop bit
  output logic            o_tbe_set,       // tx data moved
  output logic            o_tbe_clr,       // tx data written
  output logic            o_tc_set,        // frame sent
  output logic            o_cts_n          // nCTS pin
);
  logic [7:0] p_q = 8'h00;

  assign {o_tc_set, o_tbe_clr, o_tbe_set, o_break_stop} = p_q[7:4];
  assign {o_baud_tick, o_idle_line, o_rx_char_valid, o_rx_start} = p_q[3:0];

  initial begin
    o_rx_char = 8'h00;
    o_rx_busy = 1'b0;
    o_cts_n   = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle pulse: 0 start,1 char,2 idle,3 tick,4 brk stop,5-7 tx
  task automatic pulse(input int k);
    @(posedge i_clk);
    p_q <= 8'h01 << k;
    @(posedge i_clk);
    p_q <= 8'h00;
  endtask : pulse

  task automatic send_char(input logic [7:0] c);
    @(posedge i_clk);
    o_rx_busy <= 1'b1;
    p_q       <= 8'h01;
    @(posedge i_clk);
    p_q       <= 8'h02;
    o_rx_char <= c;
    @(posedge i_clk);
    p_q       <= 8'h00;
    o_rx_busy <= 1'b0;
    // released data lines do not keep the old value
    o_rx_char <= ~c;
  endtask : send_char

  task automatic set_busy(input logic v);
    @(posedge i_clk);
    o_rx_busy <= v;
  endtask : set_busy

  // pin reaches the status bit after 2 cycles and the change flag after 3
  task automatic set_cts(input logic v);
    @(posedge i_clk);
    o_cts_n <= v;
    repeat (3) @(posedge i_clk);
  endtask : set_cts
endmodule : usf_far_model

// [dv/usf_status_test.sv]
`timescale 1ns/10ps
`include "usf_map.svh"

module usf_status_test;
  logic        i_clk   = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic        rd      = 1'b0;
  logic        wr      = 1'b0;
  logic [31:0] wdat    = 32'h00000000;
  logic        dsl     = 1'b0;
  logic        ce      = 1'b1;
  logic [3:0]  be      = 4'hF;
  logic [31:0] rdat;
  logic        wreq;
  logic        st, cv, idl, tk, bs, ts, tcl, tcs, rx_path_busy, ctsn;
  logic [7:0]  ch;
  logic        brk, mute, wirq, mirq, birq, tirq, txe, rxe, cirq;
  logic [31:0] sv;
  logic [1:0]  src [3] = '{2'b00, 2'b01, 2'b11};
  int          err_total = 0;
  int          cmp_count = 0;
  int          cyc       = 0;

  usf_status i_usf_status (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_rx_start(st), .i_rx_char_valid(cv), .i_rx_char(ch), .i_rx_busy(rx_path_busy),
    .i_idle_line(idl), .i_baud_tick(tk), .i_break_stop(bs), .i_tbe_set(ts),
    .i_tbe_clr(tcl), .i_tc_set(tcs), .i_deep_sleep(dsl), .i_cts_n(ctsn),
    .o_tx_en(txe), .o_rx_en(rxe), .o_rx_mute(mute), .o_break_req(brk),
    .o_wake_irq(wirq), .o_match_irq(mirq), .o_block_end_irq(birq),
    .o_timeout_irq(tirq), .o_cts_irq(cirq)
  );

  usf_far_model i_usf_far_model (
    .i_clk(i_clk), .o_rx_start(st), .o_rx_char_valid(cv), .o_rx_char(ch),
    .o_rx_busy(rx_path_busy), .o_idle_line(idl), .o_baud_tick(tk), .o_break_stop(bs),
    .o_tbe_set(ts), .o_tbe_clr(tcl), .o_tc_set(tcs), .o_cts_n(ctsn)
  );

  initial begin
    forever #5 i_clk = ~i_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // request held until the rising edge that samples waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    adr  <= a;
    wdat <= d;
    wr   <= w;
    rd   <= !w;
    do begin
      @(posedge i_clk);
    end while (wreq);
    sv = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic rstat(input int b, input logic e);
    bus(1'b0, `USF_STAT_OFS, 32'h0);
    chk(sv[b], e);
  endtask : rstat

  task automatic ticks(input int n);
    repeat (n) i_usf_far_model.pulse(3);
  endtask : ticks

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    bus(1'b0, `USF_STAT_OFS, 32'h0);
    chk(sv, `USF_STAT_RST);
    bus(1'b1, `USF_STAT_OFS, 32'hFFFFFFFF);
    bus(1'b0, `USF_STAT_OFS, 32'h0);
    chk(sv, `USF_STAT_RST);
    bus(1'b1, 8'h40, 32'hFFFFFFFF);
    bus(1'b0, 8'h40, 32'h0);
    chk(sv, 32'h0);
    // enables and acknowledges
    bus(1'b1, `USF_CTL_OFS, 32'h5A000083);
    rstat(22, 1'b1);
    rstat(21, 1'b1);
    chk(rxe, 1'b1);
    chk(txe, 1'b1);
    bus(1'b1, `USF_CTL_OFS, 32'h5A000082);
    rstat(21, 1'b0);
    chk(txe, 1'b0);
    // station match
    i_usf_far_model.send_char(8'h12);
    rstat(17, 1'b0);
    i_usf_far_model.send_char(8'h5A);
    rstat(17, 1'b1);
    chk(mirq, 1'b1);
    bus(1'b1, `USF_INTC_OFS, 32'h00020000);
    rstat(17, 1'b0);
    chk(mirq, 1'b0);
    // busy and clear-to-send
    i_usf_far_model.set_busy(1'b1);
    rstat(16, 1'b1);
    i_usf_far_model.set_busy(1'b0);
    rstat(16, 1'b0);
    i_usf_far_model.set_cts(1'b0);
    rstat(10, 1'b1);
    rstat(9, 1'b1);
    bus(1'b1, `USF_INTC_OFS, 32'h00000200);
    rstat(9, 1'b0);
    i_usf_far_model.set_cts(1'b1);
    rstat(10, 1'b0);
    chk(cirq, 1'b0);
    bus(1'b1, `USF_CTL_OFS, 32'h5A000882);
    rstat(9, 1'b1);
    chk(cirq, 1'b1);
    // break request
    bus(1'b1, `USF_CMD_OFS, 32'h00000002);
    rstat(18, 1'b1);
    chk(brk, 1'b1);
    i_usf_far_model.pulse(4);
    rstat(18, 1'b0);
    chk(brk, 1'b0);
    // mute, idle-line method then address method
    i_usf_far_model.send_char(8'h85);
    rstat(19, 1'b0);
    bus(1'b1, `USF_CMD_OFS, 32'h00000004);
    rstat(19, 1'b1);
    chk(mute, 1'b1);
    i_usf_far_model.pulse(2);
    rstat(19, 1'b0);
    bus(1'b1, `USF_CTL_OFS, 32'h5A000086);
    i_usf_far_model.send_char(8'h85);
    rstat(19, 1'b1);
    i_usf_far_model.send_char(8'h5A);
    rstat(19, 1'b0);
    // block end at length 1 plus 4 bytes
    bus(1'b1, `USF_CTL_OFS, 32'h5A000182);
    bus(1'b1, `USF_RT_OFS, 32'h01000003);
    // a clear meeting a full count loses to the set; the second one lands
    repeat (2) bus(1'b1, `USF_INTC_OFS, 32'h00001800);
    repeat (4) i_usf_far_model.send_char(8'h33);
    rstat(12, 1'b0);
    i_usf_far_model.send_char(8'h33);
    rstat(12, 1'b1);
    chk(birq, 1'b1);
    repeat (2) bus(1'b1, `USF_INTC_OFS, 32'h00001000);
    rstat(12, 1'b0);
    chk(birq, 1'b0);
    // timeout threshold 3, standard then smartcard
    bus(1'b1, `USF_CTL_OFS, 32'h5A000382);
    i_usf_far_model.send_char(8'h33);
    ticks(2);
    rstat(11, 1'b0);
    ticks(1);
    rstat(11, 1'b1);
    chk(tirq, 1'b1);
    bus(1'b1, `USF_INTC_OFS, 32'h00000800);
    i_usf_far_model.pulse(0);
    ticks(3);
    rstat(11, 1'b0);
    bus(1'b1, `USF_CTL_OFS, 32'h5A0003C2);
    i_usf_far_model.pulse(0);
    ticks(3);
    rstat(11, 1'b1);
    // wake sources: match, start bit, received char
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, `USF_CTL_OFS, 32'h5A00040A | (32'(src[k]) << 4));
      bus(1'b1, `USF_INTC_OFS, 32'h00100000);
      if (k == 1) begin
        i_usf_far_model.pulse(0);
      end else begin
        i_usf_far_model.send_char(k == 0 ? 8'h5A : 8'h12);
      end
      rstat(20, 1'b1);
    end
    chk(wirq, 1'b0);
    @(posedge i_clk) dsl <= 1'b1;
    @(negedge i_clk);
    chk(wirq, 1'b1);
    bus(1'b1, `USF_INTC_OFS, 32'h00100000);
    rstat(20, 1'b0);
    chk(wirq, 1'b0);
    i_usf_far_model.send_char(8'h12);
    rstat(20, 1'b1);
    bus(1'b1, `USF_CTL_OFS, 32'h5A000432);
    rstat(20, 1'b0);
    // frozen clock enable: a matching char goes unseen
    bus(1'b1, `USF_INTC_OFS, 32'h00020000);
    @(posedge i_clk) ce <= 1'b0;
    i_usf_far_model.send_char(8'h5A);
    @(posedge i_clk) ce <= 1'b1;
    rstat(17, 1'b0);
    i_usf_far_model.send_char(8'h5A);
    rstat(17, 1'b1);
    // byte lanes: only the station byte is written
    be <= 4'h8;
    bus(1'b1, `USF_CTL_OFS, 32'h12FFFFFF);
    be <= 4'hF;
    bus(1'b0, `USF_CTL_OFS, 32'h0);
    chk(sv, 32'h12000432);
    // tx buffer empty and complete leave their reset state
    i_usf_far_model.pulse(6);
    i_usf_far_model.pulse(7);
    rstat(7, 1'b0);
    rstat(6, 1'b0);
    i_usf_far_model.pulse(5);
    i_usf_far_model.pulse(7);
    rstat(7, 1'b1);
    rstat(6, 1'b1);
    bus(1'b1, `USF_INTC_OFS, 32'h00000040);
    rstat(6, 1'b0);
    // second reset in mid-run restores the status word
    @(posedge i_clk) i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    bus(1'b0, `USF_STAT_OFS, 32'h0);
    chk(sv, `USF_STAT_RST);
    end_of_test();
  end
endmodule : usf_status_test
